// ---- src/adc_seq_ctrl.sv ----
// sample sequencers, averaging and digital comparators with apb registers
//
// Contract
// - four sequencers, depths eight, four, four, one
// - each step picks any channel or sensor
// - each sequencer has own trigger source
// - highest priority pending sequencer served first
// - averaging 2x to 64x, shared by all
// - one averaged result per sample group
// - fault and irq modes evaluated in parallel
// - disabled fault mode never asserts fault
// - always mode asserts on every band result
// - once mode asserts only on band entry
// - low hysteresis every needs high since last
// - high hysteresis every needs low since last
// - low hysteresis entry needs high since last
// - high hysteresis entry needs low since last
// - irq path same modes, off never fires
// - low at or below low, high above high
// - fault and irq history cleared separately
// - averaging factor zero delivers raw conversions
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`include "adc_seq_defines.svh"
module adc_seq_ctrl
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // external trigger pins
    input wire logic [3:0] EXT_TRIG,
    // conversion core
    output conv_req_t CONV,
    input wire logic CONV_DONE,
    input wire logic [11:0] CONV_DATA,
    // results and comparator events
    output result_t RESULT,
    output logic [1:0] FAULT_TRIG,
    output logic [1:0] CMP_IRQ
);
    ctrl_state_t q;
    ctrl_state_t n;
    logic done;
    logic [4:0] flat;
    logic [2:0] last;
    logic [6:0] target;
    logic [17:0] acc_new;
    logic group_end;
    logic [11:0] avg_data;
    logic [7:0] cur_step;
    logic cmp_sel;
    band_t band;
    logic [3:0] ext_rise;

    // --------------------------------------------------------------
    // comparator path
    // --------------------------------------------------------------
    function automatic path_out_t path_eval(input cmp_mode_t m, input band_t b,
                                            input path_hist_t h);
        path_out_t o;
        logic entry;
        entry = (b != h.prev);
        o.fire = 1'b0;
        o.hist.prev = b;
        o.hist.armed = 1'b0;
        case (m)
            fault_low_band_every: o.fire = (b == BAND_LOW);
            fault_low_band_entry: o.fire = (b == BAND_LOW) && entry;
            fault_low_band_hyst_every: o.fire = (b == BAND_LOW) && h.armed;
            fault_low_band_hyst_entry: o.fire = (b == BAND_LOW) && entry && h.armed;
            fault_mid_band_every: o.fire = (b == BAND_MID);
            fault_mid_band_entry: o.fire = (b == BAND_MID) && entry;
            fault_high_band_every: o.fire = (b == BAND_HIGH);
            fault_high_band_entry: o.fire = (b == BAND_HIGH) && entry;
            fault_high_band_hyst_every: o.fire = (b == BAND_HIGH) && h.armed;
            fault_high_band_hyst_entry: o.fire = (b == BAND_HIGH) && entry && h.armed;
            default: o.fire = 1'b0;
        endcase
        if (m == fault_low_band_hyst_every || m == fault_low_band_hyst_entry) begin
            o.hist.armed = (b == BAND_HIGH) | (h.armed & ~o.fire);
        end
        if (m == fault_high_band_hyst_every || m == fault_high_band_hyst_entry) begin
            o.hist.armed = (b == BAND_LOW) | (h.armed & ~o.fire);
        end
        return o;
    endfunction

    // --------------------------------------------------------------
    // datapath helpers
    // --------------------------------------------------------------
    always_comb begin
        case (q.seq)
            2'h0: flat = 5'(q.idx);
            2'h1: flat = `SEQ1_BASE + 5'(q.idx);
            2'h2: flat = `SEQ2_BASE + 5'(q.idx);
            default: flat = `SEQ3_BASE;
        endcase
        case (q.seq)
            2'h0: last = q.len[2:0];
            2'h1: last = {1'b0, q.len[5:4]};
            2'h2: last = {1'b0, q.len[9:8]};
            default: last = 3'h0;
        endcase
    end

    assign done = (q.st == ST_WAIT) & CONV_DONE;
    assign target = 7'h01 << q.avg;
    assign acc_new = q.acc + 18'(CONV_DATA);
    assign group_end = (7'(q.cnt + 7'h01) == target);
    assign avg_data = 12'(acc_new >> q.avg);
    assign cur_step = q.step[flat];
    assign cmp_sel = cur_step[6];
    assign band = (avg_data <= q.clow[cmp_sel]) ? BAND_LOW :
                  (avg_data <= q.chigh[cmp_sel]) ? BAND_MID : BAND_HIGH;
    assign ext_rise = q.s2 & ~q.s3;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        logic wr;
        logic hit;
        logic [31:0] rd;
        logic [3:0] swt;
        logic [3:0] set;
        logic [3:0] take;
        logic found;
        logic [1:0] best;
        logic [1:0] bestp;
        logic [4:0] sidx;
        path_out_t pf;
        path_out_t pi;
        n = q;
        wr = PSEL & PENABLE & PWRITE;
        hit = 1'b1;
        rd = 32'h0000_0000;
        swt = 4'h0;
        set = 4'h0;
        take = 4'h0;
        found = 1'b0;
        best = 2'h0;
        bestp = 2'h3;
        sidx = 5'(PADDR[7:2] - 6'h10);
        pf = '0;
        pi = '0;
        n.s1 = EXT_TRIG;
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.conv.req = 1'b0;
        n.res.valid = 1'b0;
        n.fault = 2'h0;
        n.irq = 2'h0;
        // register decode
        case (PADDR)
            `OFS_CTRL: rd = {25'h0, q.avg, q.en};
            `OFS_PRIO: rd = {24'h0, q.prio};
            `OFS_TSEL: rd = {24'h0, q.tsel};
            `OFS_SWTRIG: rd = 32'h0000_0000;
            `OFS_LEN: rd = {22'h0, q.len};
            `OFS_STATUS: rd = {4'h0, q.hf[1].prev, q.hf[0].prev, 4'h0, q.pend,
                               5'h00, q.idx, 2'h0, q.seq, 1'b0, q.st};
            `OFS_CMPCFG: rd = {16'h0, q.ccfg[1], q.ccfg[0]};
            `OFS_CMPLVL0: rd = {4'h0, q.chigh[0], 4'h0, q.clow[0]};
            `OFS_CMPLVL1: rd = {4'h0, q.chigh[1], 4'h0, q.clow[1]};
            `OFS_CMPCLR: rd = 32'h0000_0000;
            default: begin
                if (PADDR >= `OFS_STEP0 && PADDR < `OFS_STEPEND && PADDR[1:0] == 2'h0) begin
                    rd = {24'h0, q.step[sidx]};
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
        if (PSEL & ~PENABLE) begin
            n.rdata = rd;
            n.err = ~hit;
        end
        if (wr) begin
            case (PADDR)
                `OFS_CTRL: begin
                    n.en = PWDATA[3:0];
                    n.avg = (PWDATA[6:4] > `AVG_MAX) ? `AVG_MAX : PWDATA[6:4];
                end
                `OFS_PRIO: n.prio = PWDATA[7:0];
                `OFS_TSEL: n.tsel = PWDATA[7:0];
                `OFS_SWTRIG: swt = PWDATA[3:0];
                `OFS_LEN: n.len = PWDATA[9:0];
                `OFS_CMPCFG: n.ccfg = PWDATA[15:0];
                `OFS_CMPLVL0: begin
                    n.clow[0] = PWDATA[11:0];
                    n.chigh[0] = PWDATA[`LVL_HIGH_LSB +: 12];
                end
                `OFS_CMPLVL1: begin
                    n.clow[1] = PWDATA[11:0];
                    n.chigh[1] = PWDATA[`LVL_HIGH_LSB +: 12];
                end
                `OFS_CMPCLR: begin
                    if (PWDATA[0]) n.hf[0] = '0;
                    if (PWDATA[1]) n.hi[0] = '0;
                    if (PWDATA[2]) n.hf[1] = '0;
                    if (PWDATA[3]) n.hi[1] = '0;
                end
                default: begin
                    if (hit && PADDR >= `OFS_STEP0) n.step[sidx] = PWDATA[7:0];
                end
            endcase
        end
        // trigger sources
        for (int i = 0; i < 4; i++) begin
            case (trig_src_t'(q.tsel[2*i +: 2]))
                TRIG_SOFT: set[i] = swt[i];
                TRIG_EXT: set[i] = ext_rise[i];
                TRIG_ALWAYS: set[i] = 1'b1;
                default: set[i] = 1'b0;
            endcase
        end
        set = set & q.en;
        // arbitration
        for (int i = 0; i < 4; i++) begin
            if (q.pend[i] && q.en[i] && (!found || q.prio[2*i +: 2] < bestp)) begin
                found = 1'b1;
                best = 2'(i);
                bestp = q.prio[2*i +: 2];
            end
        end
        // sequencer
        case (q.st)
            ST_IDLE: begin
                if (found) begin
                    take[best] = 1'b1;
                    n.seq = best;
                    n.idx = 3'h0;
                    n.acc = 18'h0_0000;
                    n.cnt = 7'h00;
                    n.st = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                n.conv.req = 1'b1;
                n.conv.chan = cur_step[4:0];
                n.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (done) begin
                    n.acc = acc_new;
                    n.cnt = 7'(q.cnt + 7'h01);
                    n.st = ST_ISSUE;
                    if (group_end) begin
                        n.acc = 18'h0_0000;
                        n.cnt = 7'h00;
                        n.res.valid = 1'b1;
                        n.res.seq = q.seq;
                        n.res.step = q.idx;
                        n.res.data = avg_data;
                        if (cur_step[5]) begin
                            pf = path_eval(cmp_mode_t'(q.ccfg[cmp_sel][3:0]), band,
                                           q.hf[cmp_sel]);
                            pi = path_eval(cmp_mode_t'(q.ccfg[cmp_sel][7:4]), band,
                                           q.hi[cmp_sel]);
                            n.hf[cmp_sel] = pf.hist;
                            n.hi[cmp_sel] = pi.hist;
                            n.fault[cmp_sel] = pf.fire;
                            n.irq[cmp_sel] = pi.fire;
                        end
                        if (q.idx == last) begin
                            n.st = ST_IDLE;
                        end else begin
                            n.idx = 3'(q.idx + 3'h1);
                        end
                    end
                end
            end
            default: n.st = ST_IDLE;
        endcase
        n.pend = (q.pend & ~take) | set;
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.prio <= `PRIO_RST;
            q.tsel <= `TSEL_RST;
            q.len <= `LEN_RST;
            q.clow <= {`LOW_RST, `LOW_RST};
            q.chigh <= {`HIGH_RST, `HIGH_RST};
        end else begin
            q <= n;
        end
    end

    assign PRDATA = q.rdata;
    assign PREADY = 1'b1;
    assign PSLVERR = q.err;
    assign CONV = q.conv;
    assign RESULT = q.res;
    assign FAULT_TRIG = q.fault;
    assign CMP_IRQ = q.irq;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SYS_RST);

    a_fault_off_quiet: assert property (
        $past(q.ccfg[0][3:0]) == 4'h0 |-> !FAULT_TRIG[0])
        else $error("fault fired while path off");
    a_irq_off_quiet: assert property (
        $past(q.ccfg[0][7:4]) == 4'h0 |-> !CMP_IRQ[0])
        else $error("irq fired while path off");
    a_avg_group_len: assert property (
        RESULT.valid && $stable(q.avg) |-> $past(q.cnt) == 7'((7'h01 << q.avg) - 7'h01))
        else $error("result not at end of group");
    a_prio_order: assert property (
        q.st == ST_IDLE && (q.pend[1:0] & q.en[1:0]) == 2'h3
        && q.prio[1:0] < q.prio[3:2] && !q.pend[2] && !q.pend[3] |=> q.seq == 2'h0)
        else $error("lower priority served first");
    a_every_low: assert property (
        done && group_end && cur_step[5] && !cmp_sel && band == BAND_LOW
        && q.ccfg[0][3:0] == 4'h1 |=> FAULT_TRIG[0])
        else $error("low every missed");
    a_entry_repeat: assert property (
        done && group_end && cur_step[5] && !cmp_sel && band == q.hf[0].prev
        && q.ccfg[0][3:0] == 4'h2 |=> !FAULT_TRIG[0])
        else $error("entry fired twice");
    a_hyst_unarmed: assert property (
        !q.hf[0].armed && q.ccfg[0][3:0] == 4'h3 |=> !FAULT_TRIG[0])
        else $error("hysteresis fired unarmed");
    a_clear_history: assert property (
        PSEL && PENABLE && PWRITE && PADDR == `OFS_CMPCLR && PWDATA[0]
        && !(done && group_end) |=> q.hf[0] == '0)
        else $error("history not cleared");
    a_chan_from_step: assert property (
        q.st == ST_ISSUE |=> CONV.req && CONV.chan == $past(cur_step[4:0]))
        else $error("wrong channel issued");
    a_single_step: assert property (
        q.st != ST_IDLE && q.seq == 2'h3 |-> q.idx == 3'h0)
        else $error("fourth sequencer past one step");
endmodule

// ---- include/adc_seq_defines.svh ----
// register offsets, field positions and reset values of the sequencer block
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH
`define OFS_CTRL 8'h00
`define OFS_PRIO 8'h04
`define OFS_TSEL 8'h08
`define OFS_SWTRIG 8'h0C
`define OFS_LEN 8'h10
`define OFS_STATUS 8'h14
`define OFS_CMPCFG 8'h18
`define OFS_CMPLVL0 8'h1C
`define OFS_CMPLVL1 8'h20
`define OFS_CMPCLR 8'h24
`define OFS_STEP0 8'h40
`define OFS_STEPEND 8'h84
`define CTRL_AVG_LSB 4
`define AVG_MAX 3'h6
`define LVL_HIGH_LSB 16
`define PRIO_RST 8'hE4
`define TSEL_RST 8'h00
`define LEN_RST 10'h000
`define LOW_RST 12'h000
`define HIGH_RST 12'hFFF
`define SEQ1_BASE 5'h08
`define SEQ2_BASE 5'h0C
`define SEQ3_BASE 5'h10
`endif

// ---- include/adc_seq_pkg.sv ----
// types of the sequencer and digital comparator block
package adc_seq_pkg;
    typedef enum logic [3:0] {
        fault_path_off = 4'h0,
        fault_low_band_every = 4'h1,
        fault_low_band_entry = 4'h2,
        fault_low_band_hyst_every = 4'h3,
        fault_low_band_hyst_entry = 4'h4,
        fault_mid_band_every = 4'h5,
        fault_mid_band_entry = 4'h6,
        fault_high_band_every = 4'h7,
        fault_high_band_entry = 4'h8,
        fault_high_band_hyst_every = 4'h9,
        fault_high_band_hyst_entry = 4'hA
    } cmp_mode_t;
    typedef enum logic [1:0] {
        BAND_NONE = 2'h0, BAND_LOW = 2'h1, BAND_MID = 2'h2, BAND_HIGH = 2'h3
    } band_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001, ST_ISSUE = 3'b010, ST_WAIT = 3'b100
    } seq_state_t;
    typedef enum logic [1:0] {
        TRIG_SOFT = 2'h0, TRIG_EXT = 2'h1, TRIG_ALWAYS = 2'h2, TRIG_OFF = 2'h3
    } trig_src_t;
    typedef struct packed {
        logic req;
        logic [4:0] chan;
    } conv_req_t;
    typedef struct packed {
        logic valid;
        logic [1:0] seq;
        logic [2:0] step;
        logic [11:0] data;
    } result_t;
    typedef struct packed {
        band_t prev;
        logic armed;
    } path_hist_t;
    typedef struct packed {
        logic fire;
        path_hist_t hist;
    } path_out_t;
    typedef struct packed {
        seq_state_t st;
        logic [3:0] en;
        logic [2:0] avg;
        logic [7:0] prio;
        logic [7:0] tsel;
        logic [9:0] len;
        logic [16:0][7:0] step;
        logic [1:0][7:0] ccfg;
        logic [1:0][11:0] clow;
        logic [1:0][11:0] chigh;
        logic [3:0] pend;
        logic [1:0] seq;
        logic [2:0] idx;
        logic [17:0] acc;
        logic [6:0] cnt;
        conv_req_t conv;
        result_t res;
        logic [1:0] fault;
        logic [1:0] irq;
        path_hist_t [1:0] hf;
        path_hist_t [1:0] hi;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [31:0] rdata;
        logic err;
    } ctrl_state_t;
endpackage

// ---- verification/conv_core_model.sv ----
// behavioural conversion core answering each request after a set latency
module conv_core_model
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request side
    input wire conv_req_t conv,
    input wire logic [3:0] lat,
    input wire logic [11:0] value,
    // answer side
    output logic done,
    output logic [11:0] data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy;
    logic [3:0] cnt;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            done <= 1'b0;
            data <= 12'hA5A;
        end else begin
            done <= 1'b0;
            // stale data is not held after the answer cycle
            if (done) begin
                data <= ~data;
            end
            if (busy) begin
                if (cnt == 4'h0) begin
                    done <= 1'b1;
                    data <= value;
                    busy <= 1'b0;
                end else begin
                    cnt <= cnt - 4'h1;
                end
            end else if (conv.req === 1'b1) begin
                busy <= 1'b1;
                cnt <= lat;
            end
        end
    end
endmodule

// ---- verification/adc_seq_ctrl_tb_top.sv ----
// self-checking testbench of the sequencer and digital comparator block
`include "adc_seq_defines.svh"
module adc_seq_ctrl_tb_top;
    import adc_seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk, rst, psel, penable, pwrite, pready, pslverr, er, cdone;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] ext_trig, lat;
    logic [11:0] value, cdata;
    conv_req_t conv;
    result_t result;
    logic [1:0] fault, irq;
    int errors, n_checks, n_conv;
    // fire pattern per mode, first result in the top bit
    localparam logic [9:0] fire_tab [11] = '{10'b0000000000, 10'b1100011000,
        10'b1000010000, 10'b0000010000, 10'b0000010000, 10'b0010000110, 10'b0010000100,
        10'b0001100001, 10'b0001000001, 10'b0001000001, 10'b0001000001};
    localparam logic [11:0] vals [10] = '{12'h064, 12'h064, 12'h0C8, 12'h0C9, 12'h0C9,
        12'h064, 12'h064, 12'h0C8, 12'h0C8, 12'h0C9};
    adc_seq_ctrl dut (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EXT_TRIG(ext_trig), .CONV(conv), .CONV_DONE(cdone),
        .CONV_DATA(cdata), .RESULT(result), .FAULT_TRIG(fault), .CMP_IRQ(irq));
    conv_core_model core (.clk(clk), .rst(rst), .conv(conv), .lat(lat), .value(value),
        .done(cdone), .data(cdata));
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (conv.req === 1'b1) begin
            n_conv <= n_conv + 1;
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang;
        errors++;
        $display("[FAIL] %0t wait ran out", $time);
        give_verdict;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) hang;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_res;
        int i;
        for (i = 0; i < 1000; i++) begin
            @(negedge clk);
            if (result.valid === 1'b1) break;
        end
        if (i == 1000) hang;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        apb(1'b0, `OFS_PRIO, 32'h0);
        chk(rd, 32'h000000E4);
        apb(1'b0, `OFS_CMPLVL0, 32'h0);
        chk(rd, 32'h0FFF0000);
        apb(1'b0, 8'hFC, 32'h0);
        chk({rd[30:0], er}, 32'h1);
    endtask
    task automatic t_depth;
        int k;
        lat <= 4'h0;
        for (k = 0; k < 8; k++) apb(1'b1, `OFS_STEP0 + 8'(4 * k), 32'(24 - 3 * k));
        apb(1'b1, `OFS_LEN, 32'h7);
        apb(1'b1, `OFS_CTRL, 32'h1);
        apb(1'b1, `OFS_SWTRIG, 32'h1);
        for (k = 0; k < 8; k++) begin
            wait_res;
            chk(32'({result.seq, result.step}), 32'(k));
            chk(32'(conv.chan), 32'(24 - 3 * k));
        end
        for (k = 0; k < 30; k++) begin
            @(negedge clk);
            chk(32'(result.valid), 32'h0);
        end
    endtask
    task automatic t_prio;
        int j;
        lat <= 4'h5;
        apb(1'b1, `OFS_LEN, 32'h0);
        apb(1'b1, `OFS_STEP0, 32'h11);
        apb(1'b1, `OFS_STEP0 + 8'h20, 32'h05);
        apb(1'b1, `OFS_CTRL, 32'h3);
        for (j = 0; j < 2; j++) begin
            apb(1'b1, `OFS_PRIO, j == 0 ? 32'hE1 : 32'hE4);
            apb(1'b1, `OFS_SWTRIG, 32'h3);
            wait_res;
            chk(32'(result.seq), j == 0 ? 32'h1 : 32'h0);
            chk(32'(conv.chan), j == 0 ? 32'h05 : 32'h11);
            wait_res;
            chk(32'(result.seq), j == 0 ? 32'h0 : 32'h1);
        end
    endtask
    task automatic t_ext;
        apb(1'b1, `OFS_STEP0 + 8'h30, 32'h09);
        apb(1'b1, `OFS_TSEL, 32'h10);
        apb(1'b1, `OFS_CTRL, 32'h4);
        @(posedge clk);
        ext_trig <= 4'h4;
        repeat (3) @(posedge clk);
        ext_trig <= 4'h0;
        wait_res;
        chk(32'({result.seq, conv.chan}), 32'h49);
    endtask
    task automatic t_avg;
        int a;
        int n0;
        lat <= 4'h1;
        apb(1'b1, `OFS_STEP0 + 8'h40, 32'h07);
        for (a = 0; a < 8; a++) begin
            apb(1'b1, `OFS_CTRL, 32'h8 | 32'(a << 4));
            n0 = n_conv;
            apb(1'b1, `OFS_SWTRIG, 32'h8);
            wait_res;
            chk(32'(n_conv - n0), 32'(1 << (a > 6 ? 6 : a)));
            chk(32'(result.data), 32'(value));
        end
    endtask
    task automatic feed(input logic [11:0] v);
        @(posedge clk);
        value <= v;
        apb(1'b1, `OFS_SWTRIG, 32'h8);
        wait_res;
    endtask
    task automatic t_cmp;
        int m;
        int i;
        lat <= 4'h2;
        apb(1'b1, `OFS_CTRL, 32'h8);
        apb(1'b1, `OFS_STEP0 + 8'h40, 32'h38);
        apb(1'b1, `OFS_CMPLVL0, 32'h00C80064);
        for (m = 0; m < 11; m++) begin
            apb(1'b1, `OFS_CMPCFG, 32'(m) | 32'((10 - m) << 4));
            apb(1'b1, `OFS_CMPCLR, 32'h3);
            for (i = 0; i < 10; i++) begin
                feed(vals[i]);
                chk(32'(fault), 32'(fire_tab[m][9 - i]));
                chk(32'(irq), 32'(fire_tab[10 - m][9 - i]));
            end
        end
        apb(1'b1, `OFS_CMPCFG, 32'h22);
        feed(12'h064);
        apb(1'b1, `OFS_CMPCLR, 32'h1);
        feed(12'h064);
        chk(32'({fault, irq}), 32'h4);
    endtask
    task automatic t_cmp1;
        lat <= 4'h1;
        apb(1'b1, `OFS_CMPLVL1, 32'h02000100);
        apb(1'b1, `OFS_CMPCFG, 32'h7500);
        apb(1'b1, `OFS_CMPCLR, 32'hC);
        apb(1'b1, `OFS_STEP0 + 8'h40, 32'h61);
        feed(12'h150);
        chk(32'({fault, irq}), 32'h8);
        feed(12'h201);
        chk(32'({fault, irq}), 32'h2);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rd, 32'h0D000031);
        apb(1'b1, `OFS_TSEL, 32'h80);
        wait_res;
        wait_res;
        chk(32'({result.seq, fault, irq}), 32'h32);
        apb(1'b1, `OFS_CTRL, 32'h0);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_trig = 4'h0;
        lat = 4'h0;
        value = 12'h3C5;
        errors = 0;
        n_checks = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_depth;
        t_prio;
        t_ext;
        t_avg;
        t_cmp;
        t_cmp1;
        give_verdict;
    end
endmodule
